// [hw/eelpi_mac.sv]
// EEE low power idle transmit, receive, counters, reset watchdog and RGMII clocking
//
// Implementation choices: the address-and-strobe port and the register addresses.
module eelpi_mac #(
    parameter int WDOG_CYC = eelpi_pkg::WDOG_CYCLES,
    parameter int LINK_CYC = eelpi_pkg::LINK_UP_CYCLES,
    parameter int IFG_CYC = eelpi_pkg::IFG_CYCLES,
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata_q,
    // Transmit client side
    input wire eelpi_pkg::eelpi_src_t tx_pending,
    input wire logic tx_frame_done,
    input wire logic client_lpi_req,
    output eelpi_pkg::eelpi_src_t tx_grant_q,
    // Link status from auto-negotiation and PHY
    input wire logic link_up,
    input wire logic an_eee_ok,
    input wire logic [1:0] auto_speed,
    input wire logic auto_full_duplex,
    // RGMII side
    input wire logic phy_ref_tick,
    input wire logic int_ref_tick,
    input wire logic rx_clk_tick,
    input wire logic rx_lpi_raw,
    input wire logic rx_clk_running,
    input wire logic tx_clk_running,
    output logic tx_lpi_q,
    output logic txc_q,
    output logic txc_halt_q,
    output logic clk125_int_q,
    output logic [1:0] rgmii_speed_q,
    output logic txc_delay_q,
    output logic rxc_delay_q,
    output logic phy_dom_rst_n_q,
    // Host signalling
    output logic usb_irq_q,
    output logic remote_wake_q
);
    eelpi_pkg::eelpi_st_t st_q;
    logic [5:0] mac_ctrl_q;
    logic int125_q, phy_reset_control_pulse_q, rx_en_q;
    logic [1:0] dly_q;
    logic [2:0] eee_ctrl_q;
    logic [3:0] sts_q, sts_set, sts_clr;
    logic [15:0] wake_wait_q, wake_cnt_q;
    logic [CNT_W-1:0] tx_trans_q, tx_time_q, rx_trans_q, rx_time_q;
    logic [7:0] us_cnt_q;
    logic us_tick;
    logic [31:0] link_cnt_q, wd_cnt_q;
    logic link_ok_q, wd_run_q, wd_expire;
    logic [7:0] ifg_cnt_q;
    logic [3:0] lpi_ticks_q;
    logic [2:0] rx_run_q;
    logic rx_lpi_q, rx_rise, rx_fall, rx_flip;
    logic [1:0] speed_eff;
    logic full_eff, decode_ok, ref_tick, txc_rise, lpi_exit;
    logic sel_ctrl, sel_sts;

    // Effective speed and duplex; manual field used when auto detect is off
    assign speed_eff = mac_ctrl_q[eelpi_pkg::B_AUTO_SPD] ? auto_speed :
        mac_ctrl_q[eelpi_pkg::B_SPD_LO+1:eelpi_pkg::B_SPD_LO];
    assign full_eff = mac_ctrl_q[eelpi_pkg::B_AUTO_SPD] ? auto_full_duplex : mac_ctrl_q[eelpi_pkg::B_DUPLEX];
    // Same gate serves TX requests and RX decoding; receiver enable is not part of it
    assign decode_ok = mac_ctrl_q[eelpi_pkg::B_EEE_EN] && full_eff && an_eee_ok && link_ok_q &&
        (speed_eff == eelpi_pkg::SPD_100 || speed_eff == eelpi_pkg::SPD_1000);
    assign ref_tick = int125_q ? int_ref_tick : phy_ref_tick;
    assign txc_rise = ref_tick && !txc_q && !txc_halt_q;
    assign lpi_exit = !client_lpi_req || !decode_ok;
    assign us_tick = (us_cnt_q == 8'(eelpi_pkg::US_CYCLES - 1));
    assign sel_ctrl = reg_we && reg_addr == eelpi_pkg::A_MAC_CTRL;
    assign sel_sts = reg_we && reg_addr == eelpi_pkg::A_INTERRUPT_STATUS_REG;

    // Microsecond time base
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            us_cnt_q <= 8'h00;
        end else begin
            us_cnt_q <= us_tick ? 8'h00 : us_cnt_q + 8'h01;
        end
    end

    // Writable control registers
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mac_ctrl_q <= eelpi_pkg::MAC_CTRL_RST;
            int125_q <= 1'b0;
            phy_reset_control_pulse_q <= 1'b0;
            dly_q <= 2'h0;
            eee_ctrl_q <= 3'h0;
            wake_wait_q <= eelpi_pkg::WAKE_WAIT_RST;
            rx_en_q <= 1'b0;
        end else begin
            phy_reset_control_pulse_q <= 1'b0;
            if (sel_ctrl) mac_ctrl_q <= reg_wdata[5:0];
            if (reg_we && reg_addr == eelpi_pkg::A_HARDWARE_CONFIG_REG) begin
                int125_q <= reg_wdata[eelpi_pkg::B_INT125];
                phy_reset_control_pulse_q <= reg_wdata[eelpi_pkg::B_PHY_RESET_CONTROL];
            end
            if (reg_we && reg_addr == eelpi_pkg::A_DELAY) dly_q <= reg_wdata[1:0];
            if (reg_we && reg_addr == eelpi_pkg::A_EEE_CTRL) eee_ctrl_q <= reg_wdata[2:0];
            if (reg_we && reg_addr == eelpi_pkg::A_WAKE_WAIT) wake_wait_q <= reg_wdata[15:0];
            if (reg_we && reg_addr == eelpi_pkg::A_MAC_RECEIVE_REG) rx_en_q <= reg_wdata[eelpi_pkg::B_RX_EN];
        end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_re) begin
            case (reg_addr)
                eelpi_pkg::A_MAC_CTRL: reg_rdata_q <= {26'h000_0000, mac_ctrl_q};
                eelpi_pkg::A_HARDWARE_CONFIG_REG: reg_rdata_q <= {31'h0000_0000, int125_q};
                eelpi_pkg::A_DELAY: reg_rdata_q <= {30'h0000_0000, dly_q};
                eelpi_pkg::A_EEE_CTRL: reg_rdata_q <= {29'h0000_0000, eee_ctrl_q};
                eelpi_pkg::A_INTERRUPT_STATUS_REG: reg_rdata_q <= {28'h000_0000, sts_q};
                eelpi_pkg::A_WAKE_WAIT: reg_rdata_q <= {16'h0000, wake_wait_q};
                eelpi_pkg::A_TX_TRANS: reg_rdata_q <= 32'(tx_trans_q);
                eelpi_pkg::A_TX_TIME: reg_rdata_q <= 32'(tx_time_q);
                eelpi_pkg::A_RX_TRANS: reg_rdata_q <= 32'(rx_trans_q);
                eelpi_pkg::A_RX_TIME: reg_rdata_q <= 32'(rx_time_q);
                eelpi_pkg::A_MAC_RECEIVE_REG: reg_rdata_q <= {31'h0000_0000, rx_en_q};
                default: reg_rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_q <= 32'h0000_0000;
        end
    end

    // Transmit sequencer: choice of source only ever happens in idle, after wake and IFG
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= eelpi_pkg::ST_IDLE;
            tx_grant_q <= '0;
            tx_lpi_q <= 1'b0;
            txc_halt_q <= 1'b0;
            lpi_ticks_q <= 4'h0;
            wake_cnt_q <= 16'h0000;
            ifg_cnt_q <= 8'h00;
        end else begin
            tx_grant_q <= '0;
            case (st_q)
                eelpi_pkg::ST_IDLE: begin
                    if (tx_pending.pause) begin
                        tx_grant_q.pause <= 1'b1;
                        st_q <= eelpi_pkg::ST_FRAME;
                    end else if (tx_pending.arp) begin
                        tx_grant_q.arp <= 1'b1;
                        st_q <= eelpi_pkg::ST_FRAME;
                    end else if (tx_pending.fifo) begin
                        tx_grant_q.fifo <= 1'b1;
                        st_q <= eelpi_pkg::ST_FRAME;
                    end else if (client_lpi_req && decode_ok) begin
                        tx_lpi_q <= 1'b1;
                        lpi_ticks_q <= 4'h0;
                        st_q <= eelpi_pkg::ST_LPI;
                    end
                end
                eelpi_pkg::ST_FRAME: begin
                    // A client request made mid-frame is not acted on until idle
                    if (tx_frame_done) begin
                        ifg_cnt_q <= 8'h00;
                        st_q <= eelpi_pkg::ST_IFG;
                    end
                end
                eelpi_pkg::ST_LPI: begin
                    if (txc_rise && lpi_ticks_q != 4'hF) lpi_ticks_q <= lpi_ticks_q + 4'h1;
                    if (lpi_exit && txc_halt_q) begin
                        txc_halt_q <= 1'b0;
                        lpi_ticks_q <= 4'h0;
                    end else if (lpi_exit && lpi_ticks_q >= 4'(eelpi_pkg::TXC_EXIT_MIN)) begin
                        tx_lpi_q <= 1'b0;
                        wake_cnt_q <= 16'h0000;
                        st_q <= eelpi_pkg::ST_WAKE;
                    end else if (!lpi_exit && mac_ctrl_q[eelpi_pkg::B_CLK_HALT] &&
                                 lpi_ticks_q >= 4'(eelpi_pkg::TXC_HALT_MIN)) begin
                        txc_halt_q <= 1'b1;
                    end
                end
                eelpi_pkg::ST_WAKE: begin
                    // Wake wait counted in microseconds, then the normal gap
                    if (wake_cnt_q >= wake_wait_q) begin
                        ifg_cnt_q <= 8'h00;
                        st_q <= eelpi_pkg::ST_IFG;
                    end else if (us_tick) begin
                        wake_cnt_q <= wake_cnt_q + 16'h0001;
                    end
                end
                eelpi_pkg::ST_IFG: begin
                    if (ifg_cnt_q >= 8'(IFG_CYC - 1)) st_q <= eelpi_pkg::ST_IDLE;
                    else ifg_cnt_q <= ifg_cnt_q + 8'h01;
                end
                default: st_q <= eelpi_pkg::ST_IDLE;
            endcase
        end
    end

    // TXC toggles on each selected 125 MHz reference tick unless halted
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            txc_q <= 1'b0;
        end else if (ref_tick && !txc_halt_q) begin
            txc_q <= !txc_q;
        end
    end

    // RX LPI filter, advanced on RX clock ticks only
    assign rx_flip = decode_ok && rx_clk_tick && (rx_lpi_raw != rx_lpi_q) &&
        (rx_run_q + 3'h1 >= (rx_lpi_q ? 3'(eelpi_pkg::RX_OFF_CNT) : 3'(eelpi_pkg::RX_ON_CNT)));
    assign rx_rise = rx_flip && !rx_lpi_q;
    assign rx_fall = rx_flip && rx_lpi_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rx_lpi_q <= 1'b0;
            rx_run_q <= 3'h0;
        end else if (!decode_ok) begin
            // Decoding off: drop the indication silently, no events
            rx_lpi_q <= 1'b0;
            rx_run_q <= 3'h0;
        end else if (rx_clk_tick) begin
            if (rx_flip) begin
                rx_lpi_q <= !rx_lpi_q;
                rx_run_q <= 3'h0;
            end else if (rx_lpi_raw != rx_lpi_q) begin
                rx_run_q <= rx_run_q + 3'h1;
            end else begin
                rx_run_q <= 3'h0;
            end
        end
    end

    // Link stability timer
    always_ff @(posedge mclk) begin
        if (!rst_n || !link_up) begin
            link_cnt_q <= 32'h0000_0000;
            link_ok_q <= 1'b0;
        end else if (link_cnt_q >= 32'(LINK_CYC - 1)) begin
            link_ok_q <= 1'b1;
        end else begin
            link_cnt_q <= link_cnt_q + 32'h0000_0001;
        end
    end

    // LPI counters: no power state gating, so they run in suspend too; wrap naturally
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_trans_q <= '0;
            tx_time_q <= '0;
            rx_trans_q <= '0;
            rx_time_q <= '0;
        end else begin
            if (st_q == eelpi_pkg::ST_IDLE && tx_lpi_q == 1'b0 && client_lpi_req && decode_ok &&
                tx_pending == '0) tx_trans_q <= tx_trans_q + 1'b1;
            if (tx_lpi_q && us_tick) tx_time_q <= tx_time_q + 1'b1;
            if (rx_rise) rx_trans_q <= rx_trans_q + 1'b1;
            if (rx_lpi_q && us_tick) rx_time_q <= rx_time_q + 1'b1;
        end
    end

    // PHY domain reset and its watchdog
    assign wd_expire = wd_run_q && !(rx_clk_running && tx_clk_running) && wd_cnt_q >= 32'(WDOG_CYC - 1);
    always_ff @(posedge mclk) begin
        if (!rst_n || phy_reset_control_pulse_q) begin
            phy_dom_rst_n_q <= 1'b0;
            wd_run_q <= 1'b1;
            wd_cnt_q <= 32'h0000_0000;
        end else if (wd_run_q) begin
            if (rx_clk_running && tx_clk_running) begin
                phy_dom_rst_n_q <= 1'b1;
                wd_run_q <= 1'b0;
            end else if (wd_expire) begin
                wd_run_q <= 1'b0;
            end else begin
                wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
            end
        end
    end

    // Sticky status, write one to clear; a set in the same cycle wins
    always_comb begin
        sts_set = 4'h0;
        sts_set[eelpi_pkg::S_RX_LPI] = rx_rise;
        sts_set[eelpi_pkg::S_RX_WAKE] = rx_fall && eee_ctrl_q[eelpi_pkg::B_WAKE_EN];
        sts_set[eelpi_pkg::S_WUPS] = rx_fall && eee_ctrl_q[eelpi_pkg::B_WAKE_EN];
        sts_set[eelpi_pkg::S_MRTO] = wd_expire;
        sts_clr = sel_sts ? reg_wdata[3:0] : 4'h0;
    end
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sts_q <= 4'h0;
        end else begin
            sts_q <= (sts_q & ~sts_clr) | sts_set;
        end
    end

    // Host signalling and static RGMII settings
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            usb_irq_q <= 1'b0;
            remote_wake_q <= 1'b0;
            clk125_int_q <= 1'b0;
            rgmii_speed_q <= eelpi_pkg::SPD_10;
            txc_delay_q <= 1'b0;
            rxc_delay_q <= 1'b0;
        end else begin
            usb_irq_q <= sts_q[eelpi_pkg::S_RX_LPI] && eee_ctrl_q[eelpi_pkg::B_LPI_IRQ_EN];
            remote_wake_q <= sts_q[eelpi_pkg::S_WUPS] && eee_ctrl_q[eelpi_pkg::B_RWAKE_EN];
            clk125_int_q <= int125_q;
            rgmii_speed_q <= speed_eff;
            txc_delay_q <= dly_q[eelpi_pkg::B_TXC_DLY];
            // RXC delay without TXC delay is no valid mode, so it is masked
            rxc_delay_q <= dly_q[eelpi_pkg::B_RXC_DLY] && dly_q[eelpi_pkg::B_TXC_DLY];
        end
    end

    // Checks
    sequence s_wake_out;
        st_q == eelpi_pkg::ST_WAKE ##1 st_q == eelpi_pkg::ST_WAKE;
    endsequence
    property p_pause_first;
        @(posedge mclk) disable iff (!rst_n)
        st_q == eelpi_pkg::ST_IDLE && tx_pending.pause |=> tx_grant_q.pause && !tx_grant_q.arp && !tx_grant_q.fifo;
    endproperty
    a_pause_first: assert property (p_pause_first) else $error("pause not granted first");
    property p_no_grant_in_wake;
        @(posedge mclk) disable iff (!rst_n)
        st_q != eelpi_pkg::ST_IDLE |=> tx_grant_q == '0;
    endproperty
    a_no_grant_in_wake: assert property (p_no_grant_in_wake) else $error("grant outside idle");
    property p_halt_late;
        @(posedge mclk) disable iff (!rst_n)
        $rose(txc_halt_q) |-> tx_lpi_q && $past(lpi_ticks_q) >= 4'(eelpi_pkg::TXC_HALT_MIN);
    endproperty
    a_halt_late: assert property (p_halt_late) else $error("TXC halted too early");
    property p_clock_before_exit;
        @(posedge mclk) disable iff (!rst_n)
        $fell(tx_lpi_q) |-> !$past(txc_halt_q) && $past(lpi_ticks_q) >= 4'(eelpi_pkg::TXC_EXIT_MIN);
    endproperty
    a_clock_before_exit: assert property (p_clock_before_exit) else $error("LPI dropped without TXC");
    property p_tx_count;
        @(posedge mclk) disable iff (!rst_n)
        $rose(tx_lpi_q) |-> tx_trans_q == $past(tx_trans_q) + 1'b1;
    endproperty
    a_tx_count: assert property (p_tx_count) else $error("TX transition not counted");
    property p_rx_on_filter;
        @(posedge mclk) disable iff (!rst_n)
        $rose(rx_lpi_q) |-> $past(rx_run_q) == 3'(eelpi_pkg::RX_ON_CNT - 1) &&
            $past(rx_lpi_raw && rx_clk_tick && decode_ok);
    endproperty
    a_rx_on_filter: assert property (p_rx_on_filter) else $error("RX LPI on without 3 clocks");
    property p_rx_flag;
        @(posedge mclk) disable iff (!rst_n)
        $rose(rx_lpi_q) |-> sts_q[eelpi_pkg::S_RX_LPI] ##1 rx_trans_q == $past(rx_trans_q, 2) + 1'b1;
    endproperty
    a_rx_flag: assert property (p_rx_flag) else $error("RX LPI start not flagged");
    property p_wake_defer;
        @(posedge mclk) disable iff (!rst_n)
        $fell(tx_lpi_q) && wake_wait_q != 16'h0000 |-> s_wake_out;
    endproperty
    a_wake_defer: assert property (p_wake_defer) else $error("no wake deferral");
    property p_timeout_flag;
        @(posedge mclk) disable iff (!rst_n)
        wd_expire |=> sts_q[eelpi_pkg::S_MRTO] && !phy_dom_rst_n_q;
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) else $error("timeout flag missing");
endmodule // eelpi_mac

// [hw/eelpi_pkg.sv]
// Constants, register map and types for the EEE low power idle MAC support block
package eelpi_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 200;
    localparam int US_CYCLES = CLK_MHZ;
    localparam int WDOG_MS = 8;
    localparam int WDOG_CYCLES = WDOG_MS * 1000 * CLK_MHZ;
    localparam int LINK_UP_MS = 1000;
    localparam int LINK_UP_CYCLES = LINK_UP_MS * 1000 * CLK_MHZ;
    localparam int IFG_NS = 96;
    localparam int IFG_CYCLES = (IFG_NS * CLK_MHZ + 999) / 1000;
    localparam int TXC_HALT_MIN = 9;
    localparam int TXC_EXIT_MIN = 1;
    localparam int RX_ON_CNT = 3;
    localparam int RX_OFF_CNT = 4;
    // Register offsets (byte addresses)
    localparam logic [7:0] A_MAC_CTRL = 8'h00;
    localparam logic [7:0] A_HARDWARE_CONFIG_REG = 8'h04;
    localparam logic [7:0] A_DELAY = 8'h08;
    localparam logic [7:0] A_EEE_CTRL = 8'h0C;
    localparam logic [7:0] A_INTERRUPT_STATUS_REG = 8'h10;
    localparam logic [7:0] A_WAKE_WAIT = 8'h14;
    localparam logic [7:0] A_TX_TRANS = 8'h18;
    localparam logic [7:0] A_TX_TIME = 8'h1C;
    localparam logic [7:0] A_RX_TRANS = 8'h20;
    localparam logic [7:0] A_RX_TIME = 8'h24;
    localparam logic [7:0] A_MAC_RECEIVE_REG = 8'h28;
    // Field positions
    localparam int B_EEE_EN = 0;
    localparam int B_CLK_HALT = 1;
    localparam int B_SPD_LO = 2;
    localparam int B_DUPLEX = 4;
    localparam int B_AUTO_SPD = 5;
    localparam int B_INT125 = 0;
    localparam int B_PHY_RESET_CONTROL = 1;
    localparam int B_TXC_DLY = 0;
    localparam int B_RXC_DLY = 1;
    localparam int B_LPI_IRQ_EN = 0;
    localparam int B_WAKE_EN = 1;
    localparam int B_RWAKE_EN = 2;
    localparam int S_RX_LPI = 0;
    localparam int S_RX_WAKE = 1;
    localparam int S_WUPS = 2;
    localparam int S_MRTO = 3;
    localparam int B_RX_EN = 0;
    // Reset values
    localparam logic [5:0] MAC_CTRL_RST = 6'h00;
    localparam logic [15:0] WAKE_WAIT_RST = 16'h0011;
    // Speed codes
    localparam logic [1:0] SPD_10 = 2'h0;
    localparam logic [1:0] SPD_100 = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    // Pending transmit sources
    typedef struct packed {
        logic pause;
        logic arp;
        logic fifo;
    } eelpi_src_t;
    // Transmit sequencer states
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_FRAME = 5'h02,
        ST_LPI = 5'h04,
        ST_WAKE = 5'h08,
        ST_IFG = 5'h10
    } eelpi_st_t;
endpackage : eelpi_pkg

// [tb/eelpi_phy_model.sv]
// Behavioural RGMII PHY: reference and RX clock ticks, LPI indication
module eelpi_phy_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Bench commands
    input wire logic clk_en,
    input wire logic lpi_cmd,
    // PHY side outputs
    output logic ref_tick,
    output logic rx_tick,
    output logic rx_lpi,
    output logic rx_run,
    output logic tx_run
);
    timeunit 1ns;
    timeprecision 1ps;
    // Ticks every other cycle; clocks stand still while disabled
    always_ff @(posedge mclk) begin
        ref_tick <= rst_n & clk_en & ~ref_tick;
        rx_tick <= rst_n & clk_en & ~rx_tick;
        rx_run <= rst_n & clk_en;
        tx_run <= rst_n & clk_en;
        // Undriven indication wanders so a stale level never looks valid
        rx_lpi <= clk_en ? lpi_cmd : ~rx_lpi;
    end
endmodule // eelpi_phy_model

// [tb/eelpi_mac_tb.sv]
// Self-checking bench for the EEE low power idle MAC support block
module eelpi_mac_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst_n, reg_we, reg_re, done, lpi_req, link_up, an_ok, clk_en, lpi_cmd, txc_d;
    logic ref_tick, rx_tick, rx_lpi, rx_run, tx_run, tx_lpi_q, txc_q, halt_q, int_q, tdly_q, rdly_q;
    logic dom_rst_n_q, irq_q, wake_q, afd;
    logic int_tick = 1'b0;
    logic [1:0] spd_q, aspd;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    logic [5:0] rows [5] = '{6'h3C, 6'h1A, 6'h09, 6'h34, 6'h2C};
    eelpi_pkg::eelpi_src_t pend, grant;
    int failures, comparisons, n, i, rises, r0;
    int cycles = 0;
    int lpi_cyc = 0;
    // Clock
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // TXC rises and cycles while TX LPI is up, internal reference ticks, hang guard
    always @(posedge mclk) begin
        txc_d <= txc_q;
        int_tick <= ~int_tick;
        lpi_cyc <= lpi_cyc + int'(tx_lpi_q === 1'b1);
        rises <= (tx_lpi_q !== 1'b1) ? 0 : rises + int'(txc_q && !txc_d);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    eelpi_mac #(.WDOG_CYC(50), .LINK_CYC(20), .IFG_CYC(20)) uut (.mclk(mclk), .rst_n(rst_n),
        .reg_addr(addr), .reg_wdata(wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(rdata),
        .tx_pending(pend), .tx_frame_done(done), .client_lpi_req(lpi_req), .tx_grant_q(grant),
        .link_up(link_up), .an_eee_ok(an_ok), .auto_speed(aspd), .auto_full_duplex(afd),
        .phy_ref_tick(ref_tick), .int_ref_tick(int_tick), .rx_clk_tick(rx_tick), .rx_lpi_raw(rx_lpi),
        .rx_clk_running(rx_run), .tx_clk_running(tx_run), .tx_lpi_q(tx_lpi_q), .txc_q(txc_q),
        .txc_halt_q(halt_q), .clk125_int_q(int_q), .rgmii_speed_q(spd_q), .txc_delay_q(tdly_q),
        .rxc_delay_q(rdly_q), .phy_dom_rst_n_q(dom_rst_n_q), .usb_irq_q(irq_q), .remote_wake_q(wake_q));
    eelpi_phy_model phy (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .lpi_cmd(lpi_cmd),
        .ref_tick(ref_tick), .rx_tick(rx_tick), .rx_lpi(rx_lpi), .rx_run(rx_run), .tx_run(tx_run));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        reg_we <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_re <= 1'b1;
        addr <= a;
        @(posedge mclk);
        reg_re <= 1'b0;
        @(posedge mclk);
        chk(what, exp, rdata);
    endtask
    // Read whose value may land anywhere in a window, for the microsecond timers
    task automatic rdr(input string what, input logic [7:0] a, input int lo, input int hi);
        @(posedge mclk);
        reg_re <= 1'b1;
        addr <= a;
        @(posedge mclk);
        reg_re <= 1'b0;
        @(posedge mclk);
        comparisons++;
        if ($isunknown(rdata) || rdata < lo || rdata > hi) begin
            failures++;
            $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, rdata);
        end
    endtask
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {rst_n, reg_we, reg_re, done, lpi_req, link_up, an_ok, clk_en, lpi_cmd} = '0;
        {addr, wdata, pend, failures, comparisons} = '0;
        aspd = 2'h2;
        afd = 1'b1;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rdc("wake_wait", eelpi_pkg::A_WAKE_WAIT, 32'h0000_0011);
        repeat (60) @(posedge mclk);
        chk("dom_rst", 0, 32'(dom_rst_n_q));
        rdc("timeout", eelpi_pkg::A_INTERRUPT_STATUS_REG, 32'h0000_0008);
        clk_en <= 1'b1;
        wr(eelpi_pkg::A_HARDWARE_CONFIG_REG, 32'h0000_0002);
        repeat (10) @(posedge mclk);
        chk("dom_rst", 1, 32'(dom_rst_n_q));
        wr(eelpi_pkg::A_INTERRUPT_STATUS_REG, 32'h0000_0008);
        wr(eelpi_pkg::A_HARDWARE_CONFIG_REG, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        chk("int125", 1, 32'(int_q));
        wr(eelpi_pkg::A_HARDWARE_CONFIG_REG, 32'h0000_0000);
        for (i = 0; i < 4; i++) begin
            wr(eelpi_pkg::A_DELAY, i);
            repeat (2) @(posedge mclk);
            chk("txc_dly", i % 2, 32'(tdly_q));
            chk("rxc_dly", 32'(i == 3), 32'(rdly_q));
        end
        wr(eelpi_pkg::A_MAC_CTRL, 32'h0000_001B);
        wr(eelpi_pkg::A_EEE_CTRL, 32'h0000_0007);
        link_up <= 1'b1;
        an_ok <= 1'b1;
        repeat (30) @(posedge mclk);
        chk("speed", 2, 32'(spd_q));
        aspd <= 2'h1;
        wr(eelpi_pkg::A_MAC_CTRL, 32'h0000_003B);
        repeat (2) @(posedge mclk);
        chk("auto_speed", 1, 32'(spd_q));
        wr(eelpi_pkg::A_MAC_CTRL, 32'h0000_001B);
        $display("Test setup done");
        // Source priority rows
        for (i = 0; i < 5; i++) begin
            pend <= rows[i][5:3];
            for (n = 0; n < 20 && grant === 3'h0; n++) @(posedge mclk);
            chk("grant", 32'(rows[i][2:0]), 32'(grant));
            pend <= 3'h0;
            done <= 1'b1;
            @(posedge mclk);
            done <= 1'b0;
            repeat (25) @(posedge mclk);
        end
        $display("Test priority done");
        // TX LPI entry, clock halt, exit and wake deferral
        lpi_req <= 1'b1;
        for (n = 0; n < 200 && halt_q !== 1'b1; n++) @(posedge mclk);
        repeat (2) @(posedge mclk);
        r0 = rises;
        chk("rises_halt", 1, 32'(r0 >= 9));
        chk("halt", 1, 32'(halt_q));
        repeat (5 * eelpi_pkg::US_CYCLES) @(posedge mclk);
        pend <= 3'h1;
        lpi_req <= 1'b0;
        for (n = 0; n < 200 && tx_lpi_q !== 1'b0; n++) @(posedge mclk);
        chk("rise_exit", 1, 32'(rises > r0));
        pend <= 3'h5;
        for (n = 0; n < 4000 && grant === 3'h0; n++) @(posedge mclk);
        chk("wake_grant", 32'h0000_0004, 32'(grant));
        chk("wake_wait", 1, 32'(n >= 16 * eelpi_pkg::US_CYCLES));
        pend <= 3'h0;
        done <= 1'b1;
        @(posedge mclk);
        done <= 1'b0;
        rdc("tx_trans", eelpi_pkg::A_TX_TRANS, 32'h0000_0001);
        rdr("tx_time", eelpi_pkg::A_TX_TIME, lpi_cyc / eelpi_pkg::US_CYCLES, lpi_cyc / eelpi_pkg::US_CYCLES + 1);
        $display("Test tx lpi done");
        // Short RX LPI glitch, then a real entry and exit
        lpi_cmd <= 1'b1;
        repeat (4) @(posedge mclk);
        lpi_cmd <= 1'b0;
        rdc("glitch", eelpi_pkg::A_INTERRUPT_STATUS_REG, 32'h0000_0000);
        lpi_cmd <= 1'b1;
        repeat (20) @(posedge mclk);
        rdc("rx_start", eelpi_pkg::A_INTERRUPT_STATUS_REG, 32'h0000_0001);
        chk("irq", 1, 32'(irq_q));
        repeat (3 * eelpi_pkg::US_CYCLES) @(posedge mclk);
        lpi_cmd <= 1'b0;
        repeat (20) @(posedge mclk);
        rdc("rx_end", eelpi_pkg::A_INTERRUPT_STATUS_REG, 32'h0000_0007);
        chk("wake", 1, 32'(wake_q));
        rdc("rx_trans", eelpi_pkg::A_RX_TRANS, 32'h0000_0001);
        rdc("rx_trans", eelpi_pkg::A_RX_TRANS, 32'h0000_0001);
        rdr("rx_time", eelpi_pkg::A_RX_TIME, 3, 4);
        wr(eelpi_pkg::A_INTERRUPT_STATUS_REG, 32'h0000_0007);
        wr(eelpi_pkg::A_MAC_CTRL, 32'h0000_001A);
        lpi_cmd <= 1'b1;
        repeat (20) @(posedge mclk);
        rdc("gated", eelpi_pkg::A_INTERRUPT_STATUS_REG, 32'h0000_0000);
        $display("Test rx lpi done");
        // Counters clear on a device reset
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rdc("rx_trans_rst", eelpi_pkg::A_RX_TRANS, 32'h0000_0000);
        $display("Test reset done");
        stop_test();
    end
endmodule // eelpi_mac_tb
